/* File: pgthb_pkg.sv */
// Types shared by the playback gain trim and filter block.
// Assumes the constants header is included by the design file.
package pgthb_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_GAIN = 3'b001,
    S_HPF = 3'b011,
    S_BQ = 3'b010,
    S_OUT = 3'b110
  } pgthb_st_t;
  typedef struct packed {
    logic [1:0] ch;
    logic signed [31:0] data;
  } pgthb_smp_t;
  typedef struct packed {
    pgthb_st_t st;
    logic [1:0] k;
    logic bank;
    pgthb_smp_t cur;
    logic s_ready;
    pgthb_smp_t out;
    logic out_v;
    logic [3:0][7:0] fg;
    logic [7:0] fcfg;
    logic [7:0] ctrl;
    logic [2:0][31:0] hpc;
    logic awready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pgthb_state_t;
endpackage

/* File: pgthb_regs.svh */
// Register indices, scaling shifts, reset values and fixed coefficients.
// Assumes a 32-bit AXI4-Lite bus where byte address = 4 * index.
`ifndef PGTHB_REGS_SVH
`define PGTHB_REGS_SVH
`define PGTHB_IX_FG1A 10'h068
`define PGTHB_IX_FG1B 10'h06a
`define PGTHB_IX_FG2A 10'h06f
`define PGTHB_IX_FG2B 10'h071
`define PGTHB_IX_FCFG 10'h073
`define PGTHB_IX_CTRL 10'h080
`define PGTHB_IX_STAT 10'h081
`define PGTHB_IX_HPN0 10'h090
`define PGTHB_IX_HPN1 10'h091
`define PGTHB_IX_HPD1 10'h092
`define PGTHB_IX_BQ 10'h100
`define PGTHB_BQ_WORDS 10'h080
`define PGTHB_FG_RST 8'h80
`define PGTHB_FCFG_RST 8'h14
`define PGTHB_HPN0_RST 32'h07ffffff
`define PGTHB_HPN1_RST 32'h00000000
`define PGTHB_HPD1_RST 32'h00000000
`define PGTHB_BQN0_RST 32'h7fffffff
`define PGTHB_UNITY 32'h7fffffff
`define PGTHB_D1_SEL1 32'h7ffbe1df
`define PGTHB_D1_SEL2 32'h7fcc8735
`define PGTHB_D1_SEL3 32'h7e644494
`define PGTHB_GAIN_SH 15
`define PGTHB_COEF_SH 31
`define PGTHB_RESP_OK 2'b00
`define PGTHB_RESP_ERR 2'b10
`endif

/* File: pgthb_src.sv */
// Sample source model standing in for the serial receive path.
// Assumes the block's sys_clk and rst_b; a sample moves on valid and ready.
`timescale 1ns/1ps
module pgthb_src (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_b,
  // Requests from the bench.
  input wire logic req,
  input wire logic [3:0] dly,
  input wire pgthb_pkg::pgthb_smp_t smp,
  // Stream towards the block.
  output pgthb_pkg::pgthb_smp_t s_in = '0,
  output logic s_in_valid = 1'b0,
  input wire logic s_in_ready
);
  pgthb_pkg::pgthb_smp_t hold_q;
  logic [3:0] wait_q;
  logic pend_q;
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      s_in_valid <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      if (req) begin
        pend_q <= 1'b1;
        wait_q <= dly;
        hold_q <= smp;
      end else if (pend_q && wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end else if (pend_q) begin
        pend_q <= 1'b0;
        s_in_valid <= 1'b1;
        s_in <= hold_q;
      end
      // A taken sample is not left on the lines, so stale data cannot pass.
      if (s_in_valid && s_in_ready) begin
        s_in_valid <= 1'b0;
        s_in.data <= ~s_in.data;
      end
    end
  end
endmodule

/* File: pgthb_top.sv */
// Playback fine gain trim, shared high-pass and allocated biquads, AXI4-Lite.
// Assumes samples come from logic on sys_clk, one at a time, tagged by channel.
//
// How it works
// R01: Each channel is scaled by a fine gain from -0.8dB to +0.7dB in 0.1dB steps.
// R02: Gain code 0 is -0.8dB, +0.1dB per step, code 8 is 0dB and default.
// R03: Channels 1A, 1B, 2A and 2B each hold their own gain code register.
// R04: One high-pass setting is shared by all four channels.
// R05: Selector 00 programmable, 01 default 0.00002fs, 10 0.00025fs, 11 0.002fs.
// R06: Selector 00 runs first-order IIR (N0+N1/z)/(2^31-D1/z) with host coefficients.
// R07: IIR coefficients reset to N0 0x7FFFFFF, N1 and D1 zero.
// R08: Host writes IIR coefficients before powering up playback.
// R09: Up to twelve biquads, at most three on any one channel.
// R10: Biquad is (N0+2N1/z+N2/z^2)/(2^31-2D1/z-D2/z^2).
// R11: Biquads reset to a flat all-pass response.
// R12: Host writes biquad coefficients before powering up channels.
// R13: Allocation 00 bypasses all biquads.
// R14: Allocation 01 gives biquads 1-4 to channels 1-4; 10 adds 5-8.
// R15: Two coefficient banks swap on a host switch for two-channel playback.
// R16: Allocation 10 gives two biquads per channel; 9-12 only with three.
// R17: Signed coefficients; order is gain trim, high-pass, then biquads.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`include "pgthb_regs.svh"
module pgthb_top #(
  parameter int NBQ = 3
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_b,
  // AXI4-Lite write.
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read.
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Sample stream.
  input wire pgthb_pkg::pgthb_smp_t s_in,
  input wire logic s_in_valid,
  output logic s_in_ready,
  output pgthb_pkg::pgthb_smp_t m_out,
  output logic m_out_valid
);
  if (NBQ < 1 || NBQ > 3) begin : g_chk
    $error("NBQ must be 1 to 3");
  end

  pgthb_pkg::pgthb_state_t q;
  pgthb_pkg::pgthb_state_t n;
  logic signed [31:0] cf [128];
  logic signed [31:0] bqs [12][4];
  logic signed [31:0] hps [4][2];
  logic cf_we;
  logic [6:0] cf_wa;
  logic [31:0] cf_wd;
  logic hp_we;
  logic bq_we;
  logic [3:0] sec;
  logic signed [31:0] y;
  logic [1:0] bqc;
  logic [1:0] nsec;

  assign bqc = q.fcfg[3:2];
  assign nsec = (bqc > 2'(NBQ)) ? 2'(NBQ) : bqc;
  assign sec = {q.k, q.cur.ch};

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic signed [67:0] mul(input logic signed [31:0] a,
                                             input logic signed [31:0] b);
    mul = 68'(a) * 68'(b);
  endfunction

  function automatic logic signed [31:0] sat(input logic signed [67:0] v);
    if (v > 68'sh7fffffff) begin
      sat = 32'sh7fffffff;
    end else if (v < -68'sh80000000) begin
      sat = -32'sh80000000;
    end else begin
      sat = 32'(v);
    end
  endfunction

  // Linear gain in 1.15 format for each 0.1dB step.
  function automatic logic signed [31:0] gain(input logic [3:0] c);
    unique case (c)
      4'h0: gain = 32'h000074bd;
      4'h1: gain = 32'h00007618;
      4'h2: gain = 32'h00007776;
      4'h3: gain = 32'h000078d7;
      4'h4: gain = 32'h00007a3d;
      4'h5: gain = 32'h00007ba8;
      4'h6: gain = 32'h00007d16;
      4'h7: gain = 32'h00007e89;
      4'h8: gain = 32'h00008000;
      4'h9: gain = 32'h0000817c;
      4'ha: gain = 32'h000082fc;
      4'hb: gain = 32'h00008480;
      4'hc: gain = 32'h00008609;
      4'hd: gain = 32'h00008796;
      4'he: gain = 32'h00008928;
      4'hf: gain = 32'h00008abe;
    endcase
  endfunction

  function automatic logic [6:0] cfix(input logic b, input logic [3:0] s,
                                      input logic [2:0] c);
    cfix = {b, 6'(s * 4'd5 + 4'(c))};
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] o,
                                         input logic [31:0] d,
                                         input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      o[8*i +: 8] = s[i] ? d[8*i +: 8] : o[8*i +: 8];
    end
    wmerge = o;
  endfunction

  // Bit 32 flags a mapped index; the status word shows live engine state.
  function automatic logic [32:0] rdmap(input logic [9:0] ix);
    logic [32:0] r;
    r = {1'b1, 32'h0};
    if (ix >= `PGTHB_IX_BQ && ix < `PGTHB_IX_BQ + `PGTHB_BQ_WORDS) begin
      r[31:0] = cf[7'(ix - `PGTHB_IX_BQ)];
    end else begin
      case (ix)
        `PGTHB_IX_FG1A: r[7:0] = q.fg[0];
        `PGTHB_IX_FG1B: r[7:0] = q.fg[1];
        `PGTHB_IX_FG2A: r[7:0] = q.fg[2];
        `PGTHB_IX_FG2B: r[7:0] = q.fg[3];
        `PGTHB_IX_FCFG: r[7:0] = q.fcfg;
        `PGTHB_IX_CTRL: r[7:0] = q.ctrl;
        `PGTHB_IX_STAT: r[1:0] = {q.st != pgthb_pkg::S_IDLE, q.bank};
        `PGTHB_IX_HPN0: r[31:0] = q.hpc[0];
        `PGTHB_IX_HPN1: r[31:0] = q.hpc[1];
        `PGTHB_IX_HPD1: r[31:0] = q.hpc[2];
        default: r[32] = 1'b0;
      endcase
    end
    rdmap = r;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [9:0] wi;
    logic [32:0] wm;
    logic [32:0] rm;
    logic signed [31:0] x;
    logic signed [31:0] c0;
    logic signed [31:0] c1;
    logic signed [31:0] c2;
    wi = s_axi_awaddr[11:2];
    wm = rdmap(wi);
    rm = rdmap(s_axi_araddr[11:2]);
    x = q.cur.data;
    c0 = `PGTHB_UNITY;
    c1 = -`PGTHB_UNITY;
    c2 = `PGTHB_D1_SEL1;
    y = x;
    n = q;
    n.awready = 1'b0;
    n.arready = 1'b0;
    n.out_v = 1'b0;
    cf_we = 1'b0;
    cf_wa = 7'(wi - `PGTHB_IX_BQ);
    cf_wd = wmerge(cf[cf_wa], s_axi_wdata, s_axi_wstrb);
    hp_we = 1'b0;
    bq_we = 1'b0;
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (!q.awready && !q.bvalid && s_axi_awvalid && s_axi_wvalid) begin
      n.awready = 1'b1;
    end
    if (q.awready) begin
      n.bvalid = 1'b1;
      n.bresp = wm[32] ? `PGTHB_RESP_OK : `PGTHB_RESP_ERR;
      if (wi >= `PGTHB_IX_BQ && wi < `PGTHB_IX_BQ + `PGTHB_BQ_WORDS) begin
        cf_we = 1'b1;
      end
      case (wi)
        `PGTHB_IX_FG1A: if (s_axi_wstrb[0]) n.fg[0] = s_axi_wdata[7:0]; // R03
        `PGTHB_IX_FG1B: if (s_axi_wstrb[0]) n.fg[1] = s_axi_wdata[7:0]; // R03
        `PGTHB_IX_FG2A: if (s_axi_wstrb[0]) n.fg[2] = s_axi_wdata[7:0]; // R03
        `PGTHB_IX_FG2B: if (s_axi_wstrb[0]) n.fg[3] = s_axi_wdata[7:0]; // R03
        `PGTHB_IX_FCFG: if (s_axi_wstrb[0]) n.fcfg = s_axi_wdata[7:0];
        `PGTHB_IX_CTRL: if (s_axi_wstrb[0]) n.ctrl = s_axi_wdata[7:0];
        `PGTHB_IX_HPN0: n.hpc[0] = wmerge(q.hpc[0], s_axi_wdata, s_axi_wstrb);
        `PGTHB_IX_HPN1: n.hpc[1] = wmerge(q.hpc[1], s_axi_wdata, s_axi_wstrb);
        `PGTHB_IX_HPD1: n.hpc[2] = wmerge(q.hpc[2], s_axi_wdata, s_axi_wstrb);
        default: ;
      endcase
    end
    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (!q.arready && !q.rvalid && s_axi_arvalid) begin
      n.arready = 1'b1;
    end
    if (q.arready) begin
      n.rvalid = 1'b1;
      n.rdata = rm[31:0];
      n.rresp = rm[32] ? `PGTHB_RESP_OK : `PGTHB_RESP_ERR;
    end
    unique case (q.st)
      pgthb_pkg::S_IDLE: begin
        if (s_in_valid && q.s_ready) begin
          n.cur = s_in;
          n.s_ready = 1'b0;
          // Banks swap only between samples so no sample mixes two banks.
          n.bank = q.ctrl[0] & q.ctrl[1]; // R15
          n.st = pgthb_pkg::S_GAIN;
        end
      end
      pgthb_pkg::S_GAIN: begin
        n.cur.data = sat(mul(x, gain(q.fg[q.cur.ch][7:4])) >>> `PGTHB_GAIN_SH); // R01 R02
        n.st = pgthb_pkg::S_HPF; // R17
      end
      pgthb_pkg::S_HPF: begin
        unique case (q.fcfg[5:4]) // R04 R05
          2'b00: begin
            c0 = q.hpc[0]; // R06
            c1 = q.hpc[1];
            c2 = q.hpc[2];
          end
          2'b01: c2 = `PGTHB_D1_SEL1;
          2'b10: c2 = `PGTHB_D1_SEL2;
          2'b11: c2 = `PGTHB_D1_SEL3;
        endcase
        y = sat((mul(c0, x) + mul(c1, hps[q.cur.ch][0])
                 + mul(c2, hps[q.cur.ch][1])) >>> `PGTHB_COEF_SH); // R06
        hp_we = 1'b1;
        n.cur.data = y;
        n.k = 2'b00;
        n.st = (nsec == 2'b00) ? pgthb_pkg::S_OUT : pgthb_pkg::S_BQ; // R13 R17
      end
      pgthb_pkg::S_BQ: begin
        // Section number is channel + 4 * pass, covering all allocations.
        y = sat((mul(cf[cfix(q.bank, sec, 3'd0)], x)
                 + 2 * mul(cf[cfix(q.bank, sec, 3'd1)], bqs[sec][0])
                 + mul(cf[cfix(q.bank, sec, 3'd2)], bqs[sec][1])
                 + 2 * mul(cf[cfix(q.bank, sec, 3'd3)], bqs[sec][2])
                 + mul(cf[cfix(q.bank, sec, 3'd4)], bqs[sec][3]))
                >>> `PGTHB_COEF_SH); // R10 R09
        bq_we = 1'b1;
        n.cur.data = y;
        n.k = q.k + 2'b01;
        if (q.k + 2'b01 == nsec) begin // R14 R16
          n.st = pgthb_pkg::S_OUT;
        end
      end
      pgthb_pkg::S_OUT: begin
        n.out = q.cur;
        n.out_v = 1'b1;
        n.s_ready = 1'b1;
        n.st = pgthb_pkg::S_IDLE;
      end
      default: n.st = pgthb_pkg::S_IDLE;
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      q <= '0;
      q.st <= pgthb_pkg::S_IDLE;
      q.s_ready <= 1'b1;
      q.fg <= {4{`PGTHB_FG_RST}}; // R02
      q.fcfg <= `PGTHB_FCFG_RST; // R05
      q.hpc <= {`PGTHB_HPD1_RST, `PGTHB_HPN1_RST, `PGTHB_HPN0_RST}; // R07
    end else begin
      q <= n;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < 128; i++) begin
        cf[i] <= ((i % 64) % 5 == 0 && (i % 64) < 60) ? `PGTHB_BQN0_RST : 32'h0; // R11
      end
      for (int i = 0; i < 12; i++) begin
        for (int j = 0; j < 4; j++) begin
          bqs[i][j] <= 32'h0;
        end
      end
      for (int i = 0; i < 4; i++) begin
        hps[i][0] <= 32'h0;
        hps[i][1] <= 32'h0;
      end
    end else begin
      if (cf_we) begin
        cf[cf_wa] <= cf_wd;
      end
      if (hp_we) begin
        hps[q.cur.ch][0] <= q.cur.data;
        hps[q.cur.ch][1] <= y;
      end
      if (bq_we) begin
        bqs[sec][0] <= q.cur.data;
        bqs[sec][1] <= bqs[sec][0];
        bqs[sec][2] <= y;
        bqs[sec][3] <= bqs[sec][2];
      end
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.awready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign s_in_ready = q.s_ready;
  assign m_out = q.out;
  assign m_out_valid = q.out_v;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence bq_two;
    q.st == pgthb_pkg::S_BQ [*2] ##1 q.st == pgthb_pkg::S_OUT;
  endsequence

  a_gain_default: assert property ( // R02
    !$past(rst_b) |-> q.fg[0][7:4] == 4'h8 && q.fg[3][7:4] == 4'h8)
    else $error("fine gain code not 8 after reset");
  a_iir_default: assert property ( // R07
    !$past(rst_b) |-> q.hpc[0] == 32'h07ffffff && q.hpc[1] == 0 && q.hpc[2] == 0)
    else $error("iir coefficients wrong after reset");
  a_gain_unity: assert property ( // R01
    q.st == pgthb_pkg::S_GAIN && q.fg[q.cur.ch][7:4] == 4'h8
    |=> q.cur.data == $past(q.cur.data))
    else $error("0dB code changed the sample");
  a_bq_bypass: assert property ( // R13
    q.st == pgthb_pkg::S_HPF && bqc == 2'b00 |=> q.st == pgthb_pkg::S_OUT)
    else $error("biquads not bypassed");
  a_bq_one: assert property ( // R14
    q.st == pgthb_pkg::S_HPF && nsec == 2'b01
    |=> q.st == pgthb_pkg::S_BQ ##1 q.st == pgthb_pkg::S_OUT)
    else $error("one section per channel expected");
  a_bq_two: assert property ( // R16
    q.st == pgthb_pkg::S_HPF && nsec == 2'b10 |=> bq_two)
    else $error("two sections per channel expected");
  a_sec_map: assert property ( // R09
    q.st == pgthb_pkg::S_BQ |-> sec[1:0] == q.cur.ch && q.k < nsec)
    else $error("section not owned by channel");
  a_bank_hold: assert property ( // R15
    $changed(q.bank) |-> $past(q.st) == pgthb_pkg::S_IDLE)
    else $error("bank swapped mid sample");
  a_chain_order: assert property ( // R17
    s_in_valid && q.s_ready
    |=> q.st == pgthb_pkg::S_GAIN ##1 q.st == pgthb_pkg::S_HPF ##[2:5] q.out_v)
    else $error("processing order broken");
endmodule

/* File: tb.sv */
// Self-checking bench: AXI4-Lite master, sample source and output monitor.
// Assumes pgthb_top with NBQ 3 and byte address = 4 * register index.
`timescale 1ns/1ps
`include "pgthb_regs.svh"
module tb;
  typedef struct {pgthb_pkg::pgthb_smp_t s; int lat; longint tol;} pgthb_note_t;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] awaddr = '0;
  logic [11:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, s_in_valid, s_in_ready, m_out_valid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic req = 1'b0;
  logic [3:0] dly = '0;
  pgthb_pkg::pgthb_smp_t smp = '0;
  pgthb_pkg::pgthb_smp_t s_in, m_out;
  pgthb_note_t sq[$];
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int mismatches = 0;
  int total_checks = 0;
  int cyc = 0;
  int t_take = 0;
  int sel = 1;
  int alloc = 1;
  int bank = 0;
  int gc[4] = '{8, 8, 8, 8};
  int bqn0[2][12];
  longint hn0 = 32'h07ffffff;
  longint hn1 = 0;
  longint hd1 = 0;
  real fcut[4] = '{0.0, 0.00002, 0.00025, 0.002};
  longint xp[4] = '{0, 0, 0, 0};
  longint yp[4] = '{0, 0, 0, 0};
  logic [9:0] fgix[4] = '{`PGTHB_IX_FG1A, `PGTHB_IX_FG1B, `PGTHB_IX_FG2A, `PGTHB_IX_FG2B};

  always #2 sys_clk = ~sys_clk;

  pgthb_top uut (.sys_clk(sys_clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_in(s_in), .s_in_valid(s_in_valid),
    .s_in_ready(s_in_ready), .m_out(m_out), .m_out_valid(m_out_valid));
  pgthb_src src (.sys_clk(sys_clk), .rst_b(rst_b), .req(req), .dly(dly), .smp(smp),
    .s_in(s_in), .s_in_valid(s_in_valid), .s_in_ready(s_in_ready));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic bound(input int n);
    if (n >= 100) begin
      mismatches++;
      give_verdict();
    end
  endtask

  // ***********************************************************************
  // Bus and stream drivers.
  // ***********************************************************************
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    logic aw_done;
    logic w_done;
    @(posedge sys_clk);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_done = 1'b0;
    w_done = 1'b0;
    n = 0;
    // Each channel is released at its own handshake edge, never before.
    do begin
      @(posedge sys_clk);
      n++;
      if (awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(aw_done && w_done) && n < 100);
    bound(n);
    n = 0;
    while (bvalid !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    bound(n);
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    @(posedge sys_clk);
    rq.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (arready !== 1'b1 && n < 100);
    bound(n);
    arvalid <= 1'b0;
    n = 0;
    while (rvalid !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    bound(n);
    rready <= 1'b0;
  endtask

  function automatic longint model(input int c, input longint x);
    longint v, y, n0, n1, d1;
    v = (x * longint'($floor(32768.0 * 10.0 ** ((gc[c] - 8) / 200.0) + 0.5))) >>> 15;
    n0 = hn0;
    n1 = hn1;
    d1 = hd1;
    // Fixed cutoffs: unity N0, N1 = -N0, pole placed from the cutoff fraction of fs.
    if (sel != 0) begin
      n0 = 64'h7fffffff;
      n1 = -n0;
      d1 = longint'((1.0 - 6.283185307 * fcut[sel]) * 2147483648.0);
    end
    y = (n0 * v + n1 * xp[c] + d1 * yp[c]) >>> 31;
    xp[c] = v;
    yp[c] = y;
    for (int p = 0; p < alloc; p++) begin
      y = (y * bqn0[bank][c + 4 * p]) >>> 31;
    end
    return y;
  endfunction

  task automatic send(input logic [1:0] c, input longint tol);
    pgthb_note_t nt;
    logic [31:0] x;
    int n;
    @(posedge sys_clk);
    x = 32'h00100000 + 32'($urandom_range(16'hffff));
    nt.s = {c, 32'(model(c, x))};
    nt.lat = 4 + alloc;
    nt.tol = tol;
    sq.push_back(nt);
    smp <= {c, x};
    dly <= 4'($urandom_range(3));
    req <= 1'b1;
    @(posedge sys_clk);
    req <= 1'b0;
    n = 0;
    while (sq.size() > 0 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    bound(n);
  endtask

  // ***********************************************************************
  // Monitor: every answer is matched against the oldest note.
  // ***********************************************************************
  always @(posedge sys_clk) begin
    pgthb_note_t nt;
    longint dv;
    if (s_in_valid === 1'b1 && s_in_ready === 1'b1) t_take = cyc;
    if (bvalid === 1'b1 && bready === 1'b1 && bq.size() > 0) begin
      chk("bresp", 34'(bq.pop_front()), 34'(bresp));
    end
    if (rvalid === 1'b1 && rready === 1'b1 && rq.size() > 0) begin
      chk("rdata", rq.pop_front(), {rresp, rdata});
    end
    if (m_out_valid === 1'b1 && sq.size() > 0) begin
      nt = sq.pop_front();
      chk("latency", 34'(nt.lat), 34'(cyc - t_take));
      chk("channel", 34'(nt.s.ch), 34'(m_out.ch));
      dv = longint'(m_out.data) - longint'(nt.s.data);
      total_checks++;
      if (^m_out.data === 1'bx || dv > nt.tol || -dv > nt.tol) begin
        mismatches++;
        $display("wrong value m_out expected %h seen %h", nt.s.data, m_out.data);
      end
    end
    cyc++;
  end

  initial begin
    void'($urandom(59));
    for (int i = 0; i < 24; i++) bqn0[i / 12][i % 12] = 32'h7fffffff;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 4; i++) axr({fgix[i], 2'b00}, 32'h80, 2'b00);
    axr({`PGTHB_IX_FCFG, 2'b00}, 32'h14, 2'b00);
    axr({`PGTHB_IX_HPN0, 2'b00}, 32'h07ffffff, 2'b00);
    axr({`PGTHB_IX_HPN1, 2'b00}, 32'h0, 2'b00);
    axr({`PGTHB_IX_HPD1, 2'b00}, 32'h0, 2'b00);
    axr(12'h400, 32'h7fffffff, 2'b00);
    axr(12'h280, 32'h0, 2'b10);
    axw(12'h280, 32'h5a, 2'b10);
    for (int s = 1; s < 4; s++) begin
      axw({`PGTHB_IX_FCFG, 2'b00}, 32'h04 | (s << 4), 2'b00);
      sel = s;
      repeat (2) send(2'(s - 1), 8);
    end
    // Coefficients go in before the programmable path carries samples.
    axw({`PGTHB_IX_HPN0, 2'b00}, 32'h40000000, 2'b00);
    hn0 = 32'h40000000;
    axw(12'h450, 32'h40000000, 2'b00);
    bqn0[0][4] = 32'h40000000;
    for (int a = 0; a < 4; a++) begin
      axw({`PGTHB_IX_FCFG, 2'b00}, a << 2, 2'b00);
      sel = 0;
      alloc = a;
      for (int c = 0; c < 4; c++) send(2'(c), 0);
    end
    axw({`PGTHB_IX_FCFG, 2'b00}, 32'h0, 2'b00);
    alloc = 0;
    axw({`PGTHB_IX_HPN1, 2'b00}, 32'h40000000, 2'b00);
    axw({`PGTHB_IX_HPD1, 2'b00}, 32'h20000000, 2'b00);
    hn1 = 32'h40000000;
    hd1 = 32'h20000000;
    repeat (3) send(2'd0, 0);
    axw({`PGTHB_IX_HPN1, 2'b00}, 32'h0, 2'b00);
    axw({`PGTHB_IX_HPD1, 2'b00}, 32'h0, 2'b00);
    hn1 = 0;
    hd1 = 0;
    axw({`PGTHB_IX_FCFG, 2'b00}, 32'h04, 2'b00);
    alloc = 1;
    axw(12'h500, 32'h20000000, 2'b00);
    bqn0[1][0] = 32'h20000000;
    axw({`PGTHB_IX_CTRL, 2'b00}, 32'h1, 2'b00);
    send(2'd0, 0);
    axw({`PGTHB_IX_CTRL, 2'b00}, 32'h3, 2'b00);
    bank = 1;
    send(2'd0, 0);
    send(2'd1, 0);
    axr({`PGTHB_IX_STAT, 2'b00}, 32'h1, 2'b00);
    axw({`PGTHB_IX_CTRL, 2'b00}, 32'h2, 2'b00);
    bank = 0;
    send(2'd0, 0);
    axw({`PGTHB_IX_FCFG, 2'b00}, 32'h0, 2'b00);
    alloc = 0;
    for (int g = 0; g < 16; g++) begin
      axw({fgix[g % 4], 2'b00}, g << 4, 2'b00);
      gc[g % 4] = g;
      send(2'(g % 4), 64);
    end
    give_verdict();
  end
endmodule
